// File: pkg/nsov_defines.vh
`ifndef NSOV_DEFINES_VH
`define NSOV_DEFINES_VH

// Register byte offsets on the AXI4-Lite slave.
`define NSOV_OFS_CTRL        8'h00
`define NSOV_OFS_THRESH      8'h04
`define NSOV_OFS_DELAY       8'h08
`define NSOV_OFS_STATUS      8'h0c
`define NSOV_OFS_IRQ_STAT    8'h10
`define NSOV_OFS_IRQ_MASK    8'h14
`define NSOV_OFS_VOLTAGE     8'h18
`define NSOV_OFS_ELAPSED     8'h1c

// Control register fields.
`define NSOV_CTRL_ENABLE     0
`define NSOV_CTRL_START_ONLY 1

// Status register fields.
`define NSOV_ST_START        0
`define NSOV_ST_TRIP         1
`define NSOV_ST_GEN_START    2
`define NSOV_ST_GEN_TRIP     3
`define NSOV_ST_BLOCK        4

// Interrupt status and mask fields.
`define NSOV_IRQ_START       0
`define NSOV_IRQ_TRIP        1

// Reset values and setting limits.
`define NSOV_CTRL_RST        2'h0
`define NSOV_THR_RST         6'h1e
`define NSOV_THR_MIN         6'h02
`define NSOV_THR_MAX         6'h28
`define NSOV_DELAY_RST       16'h0064
`define NSOV_DELAY_MIN       16'h0032
`define NSOV_DELAY_MAX       16'hea60
`define NSOV_IRQ_RST         2'h0

// AXI responses.
`define NSOV_RESP_OKAY       2'h0
`define NSOV_RESP_SLVERR     2'h2

// Timing: one millisecond tick at the processing clock.
`define NSOV_CLK_PERIOD_NS   8
`define NSOV_TICK_NS         1000000
// 125000 cycles of 8 ns make one millisecond; sized to the 17-bit prescaler.
`define NSOV_TICK_CYCLES     17'h1e848

`endif

// File: core/nsov_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "nsov_defines.vh"

module nsov_timer #(
   parameter [16:0] TICK_CYCLES = `NSOV_TICK_CYCLES
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        run,
   input  wire [15:0] delay_ms,
   output reg  [15:0] elapsed_q,
   output reg         expired_q
);

   localparam [16:0] TICK_LAST = TICK_CYCLES - 17'h00001;

   reg [16:0] presc_q;

   // Dropping run clears everything, so each excursion times from zero.
   always @(posedge aclk) begin
      if (!aresetn || !run) begin
         presc_q   <= 17'h00000;
         elapsed_q <= 16'h0000;
         expired_q <= 1'b0;
      end else begin
         if (presc_q == TICK_LAST) begin
            presc_q <= 17'h00000;
            if (!expired_q) begin
               elapsed_q <= elapsed_q + 16'h0001;
            end
         end else begin
            presc_q <= presc_q + 17'h00001;
         end
         expired_q <= expired_q | (elapsed_q >= delay_ms);
      end
   end

endmodule
`default_nettype wire

// File: core/nsov_top.v
// Functional notes
// - Start while negative-sequence voltage exceeds threshold.
// - Delay timer runs only above threshold.
// - Internal trip when timer reaches delay setting.
// - Start-only selection suppresses general trip.
// - Block input disables start and trip.
// - General outputs combine internal signals and selections.
// - Configuration enable switches function off.
`timescale 1ns/1ns
`default_nettype none
`include "nsov_defines.vh"

module nsov_top #(
   parameter [16:0] TICK_CYCLES = `NSOV_TICK_CYCLES
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [15:0] neg_seq_voltage,
   input  wire        function_block_input,
   output reg         general_start_out,
   output reg         general_trip_out,
   output reg         irq,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   reg  [1:0]  ctrl_q;
   reg  [5:0]  thr_q;
   reg  [15:0] delay_q;
   reg  [1:0]  irq_stat_q;
   reg  [1:0]  irq_mask_q;
   reg  [15:0] volt_q;
   reg         block_q;
   reg         gen_start_prev_q;
   reg         gen_trip_prev_q;
   reg         aw_have_q;
   reg         w_have_q;
   reg  [7:0]  aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   wire        over;
   wire        run;
   wire        trip_int;
   wire [15:0] elapsed;
   wire        wr_go;
   wire [31:0] wr_merged;
   reg         wr_hit;
   reg  [1:0]  irq_set;
   reg  [31:0] rd_data;
   reg         rd_hit;

   function [31:0] merge_strb;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  strb;
      integer      i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge_strb[i*8 +: 8] = strb[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
         end
      end
   endfunction

   // Out-of-range settings saturate at the documented limits.
   function [5:0] clamp_thr;
      input [31:0] v;
      begin
         if (v < {26'h0000000, `NSOV_THR_MIN}) begin
            clamp_thr = `NSOV_THR_MIN;
         end else if (v > {26'h0000000, `NSOV_THR_MAX}) begin
            clamp_thr = `NSOV_THR_MAX;
         end else begin
            clamp_thr = v[5:0];
         end
      end
   endfunction

   function [15:0] clamp_delay;
      input [31:0] v;
      begin
         if (v < {16'h0000, `NSOV_DELAY_MIN}) begin
            clamp_delay = `NSOV_DELAY_MIN;
         end else if (v > {16'h0000, `NSOV_DELAY_MAX}) begin
            clamp_delay = `NSOV_DELAY_MAX;
         end else begin
            clamp_delay = v[15:0];
         end
      end
   endfunction

   // The voltage input is 8.8 fixed point in percent; the threshold is whole percent.
   assign over = volt_q > {2'h0, thr_q, 8'h00};
   // Blocking or switching off also stops the timer, so no trip can be pending.
   assign run  = over & ctrl_q[`NSOV_CTRL_ENABLE] & ~block_q;

   nsov_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .run       (run),
      .delay_ms  (delay_q),
      .elapsed_q (elapsed),
      .expired_q (trip_int)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         volt_q            <= 16'h0000;
         block_q           <= 1'b0;
         general_start_out <= 1'b0;
         general_trip_out  <= 1'b0;
         gen_start_prev_q  <= 1'b0;
         gen_trip_prev_q   <= 1'b0;
         irq               <= 1'b0;
      end else begin
         volt_q            <= neg_seq_voltage;
         block_q           <= function_block_input;
         general_start_out <= run & ~function_block_input;
         general_trip_out  <= trip_int & run & ~function_block_input &
                              ~ctrl_q[`NSOV_CTRL_START_ONLY];
         gen_start_prev_q  <= general_start_out;
         gen_trip_prev_q   <= general_trip_out;
         irq               <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Write channel: address and data are latched independently in either order.
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
   assign wr_go         = aw_have_q & w_have_q & ~s_axi_bvalid;

   always @* begin
      wr_hit = 1'b0;
      case (aw_addr_q)
         `NSOV_OFS_CTRL, `NSOV_OFS_THRESH, `NSOV_OFS_DELAY, `NSOV_OFS_STATUS,
         `NSOV_OFS_IRQ_STAT, `NSOV_OFS_IRQ_MASK, `NSOV_OFS_VOLTAGE,
         `NSOV_OFS_ELAPSED: begin
            wr_hit = 1'b1;
         end
         default: begin
            wr_hit = 1'b0;
         end
      endcase
   end

   function [31:0] rd_data_at;
      input [7:0] a;
      begin
         case (a)
            `NSOV_OFS_CTRL:     rd_data_at = {30'h00000000, ctrl_q};
            `NSOV_OFS_THRESH:   rd_data_at = {26'h0000000, thr_q};
            `NSOV_OFS_DELAY:    rd_data_at = {16'h0000, delay_q};
            `NSOV_OFS_IRQ_MASK: rd_data_at = {30'h00000000, irq_mask_q};
            default:            rd_data_at = 32'h00000000;
         endcase
      end
   endfunction

   assign wr_merged = merge_strb(rd_data_at(aw_addr_q), w_data_q, w_strb_q);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         aw_addr_q    <= 8'h00;
         w_data_q     <= 32'h00000000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `NSOV_RESP_OKAY;
         ctrl_q       <= `NSOV_CTRL_RST;
         thr_q        <= `NSOV_THR_RST;
         delay_q      <= `NSOV_DELAY_RST;
         irq_mask_q   <= `NSOV_IRQ_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `NSOV_RESP_OKAY : `NSOV_RESP_SLVERR;
            case (aw_addr_q)
               `NSOV_OFS_CTRL:     ctrl_q     <= wr_merged[1:0];
               `NSOV_OFS_THRESH:   thr_q      <= clamp_thr(wr_merged);
               `NSOV_OFS_DELAY:    delay_q    <= clamp_delay(wr_merged);
               `NSOV_OFS_IRQ_MASK: irq_mask_q <= wr_merged[1:0];
               default: begin
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // New events win over a write-one-to-clear landing in the same cycle.
   always @* begin
      irq_set                 = 2'h0;
      irq_set[`NSOV_IRQ_START] = general_start_out & ~gen_start_prev_q;
      irq_set[`NSOV_IRQ_TRIP]  = general_trip_out & ~gen_trip_prev_q;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= `NSOV_IRQ_RST;
      end else if (wr_go && aw_addr_q == `NSOV_OFS_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~(w_strb_q[0] ? w_data_q[1:0] : 2'h0)) | irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   // Read channel: one read in flight, answered the cycle after it is taken.
   assign s_axi_arready = ~s_axi_rvalid;

   always @* begin
      rd_hit  = 1'b1;
      rd_data = 32'h00000000;
      case ({s_axi_araddr[7:2], 2'h0})
         `NSOV_OFS_CTRL:     rd_data = {30'h00000000, ctrl_q};
         `NSOV_OFS_THRESH:   rd_data = {26'h0000000, thr_q};
         `NSOV_OFS_DELAY:    rd_data = {16'h0000, delay_q};
         `NSOV_OFS_STATUS:   rd_data = {27'h0000000, block_q, general_trip_out,
                                        general_start_out, trip_int, run};
         `NSOV_OFS_IRQ_STAT: rd_data = {30'h00000000, irq_stat_q};
         `NSOV_OFS_IRQ_MASK: rd_data = {30'h00000000, irq_mask_q};
         `NSOV_OFS_VOLTAGE:  rd_data = {16'h0000, volt_q};
         `NSOV_OFS_ELAPSED:  rd_data = {16'h0000, elapsed};
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `NSOV_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_hit ? `NSOV_RESP_OKAY : `NSOV_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// File: core/nsov_dummy_unused.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: tb/nsov_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module nsov_asserts #(
   parameter [16:0] TICK_CYCLES = 17'h1e848
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [15:0] neg_seq_voltage,
   input wire logic        function_block_input,
   input wire logic        general_start_out,
   input wire logic        general_trip_out,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Start time is counted so that a trip can be tied to the shortest legal delay.
   logic [31:0] on_q;
   always_ff @(posedge aclk)
      if (!aresetn || !general_start_out)
         on_q <= 32'h0;
      else
         on_q <= on_q + 32'h1;
   block_off_a: assert property (function_block_input |=> !general_start_out)
      else $error("start while blocked");
   block_trip_a: assert property (function_block_input |=> !general_trip_out)
      else $error("trip while blocked");
   trip_start_a: assert property (general_trip_out |-> general_start_out)
      else $error("trip without start");
   low_start_a: assert property ((neg_seq_voltage <= 16'h0200) [*2] |=> !general_start_out)
      else $error("start below least threshold");
   trip_delay_a: assert property ($rose(general_trip_out) |-> on_q > 32'h31 * TICK_CYCLES)
      else $error("trip too early");
   drop_all_a: assert property ($fell(general_start_out) |-> !general_trip_out)
      else $error("trip kept after dropout");
   bus_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write response late");
   b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
endmodule
bind nsov_top nsov_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);
`default_nettype wire

// File: tb/nsov_source.sv
`timescale 1ns/1ns
`default_nettype none
module nsov_source (
   input  wire logic        aclk,
   input  wire logic [15:0] level_cmd,
   input  wire logic        block_cmd,
   output var  logic [15:0] neg_seq_voltage = 16'h0000,
   output var  logic        function_block_input = 1'b0
);
   // The upstream stages refresh once a clock, so the level never changes mid-cycle.
   always @(posedge aclk) begin
      neg_seq_voltage      <= level_cmd;
      function_block_input <= block_cmd;
   end
endmodule
`default_nettype wire

// File: tb/test_nsov_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_nsov_top;
   logic        aclk = 0, aresetn = 0, blk = 0, function_block_input;
   logic [15:0] volt = 0, neg_seq_voltage;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        general_start_out, general_trip_out, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          n_errors = 0, cmp_count = 0, cyc = 0, c;
   logic [41:0] rows [6] = '{{8'h00, 32'h0, 2'h0}, {8'h04, 32'h1e, 2'h0},
      {8'h08, 32'h64, 2'h0}, {8'h10, 32'h0, 2'h0}, {8'h14, 32'h0, 2'h0}, {8'h20, 32'h0, 2'h2}};
   nsov_top #(.TICK_CYCLES(17'h0000a)) DUT (.*);
   nsov_source src (.aclk(aclk), .level_cmd(volt), .block_cmd(blk),
      .neg_seq_voltage(neg_seq_voltage), .function_block_input(function_block_input));
   initial forever #4 aclk = ~aclk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk("bresp", r, s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      chk("rdata", d, s_axi_rdata);
      chk("rresp", r, s_axi_rresp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // The count runs from the call, made at the voltage step or at block release; latency adds a few cycles to 50 ticks of 10.
   task automatic trip_time;
      c = 0;
      while (general_trip_out !== 1'b1 && c < 2000) begin
         @(posedge aclk);
         c++;
      end
      chk("trip_cycles", 1, c >= 495 && c <= 520);
   endtask
   task automatic outs(input logic [1:0] e);
      chk("start_trip", e, {general_start_out, general_trip_out});
   endtask
   task tally_and_finish;
      $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   initial begin
      tick(6);
      aresetn <= 1;
      foreach (rows[i]) rd(rows[i][41:34], rows[i][33:2], rows[i][1:0]);
      volt <= 16'h2000;
      tick(20);
      outs(2'b00);
      wr(8'h04, 32'h50, 2'h0);
      rd(8'h04, 32'h28, 2'h0);
      wr(8'h04, 32'h01, 2'h0);
      rd(8'h04, 32'h02, 2'h0);
      wr(8'h08, 32'h0a, 2'h0);
      rd(8'h08, 32'h32, 2'h0);
      wr(8'h04, 32'h14, 2'h0);
      wr(8'h14, 32'h3, 2'h0);
      wr(8'h0c, 32'h0, 2'h0);
      wr(8'h24, 32'h1, 2'h2);
      volt <= 16'h1400;
      wr(8'h00, 32'h1, 2'h0);
      tick(6);
      outs(2'b00);
      volt <= 16'h1401;
      trip_time;
      tick(2);
      outs(2'b11);
      chk("irq", 1, irq);
      rd(8'h10, 32'h3, 2'h0);
      wr(8'h14, 32'h0, 2'h0);
      tick(2);
      chk("irq", 0, irq);
      wr(8'h10, 32'h3, 2'h0);
      rd(8'h10, 32'h0, 2'h0);
      wr(8'h00, 32'h3, 2'h0);
      tick(3);
      outs(2'b10);
      rd(8'h0c, 32'h07, 2'h0);
      blk <= 1;
      tick(4);
      outs(2'b00);
      rd(8'h0c, 32'h10, 2'h0);
      wr(8'h00, 32'h1, 2'h0);
      blk <= 0;
      trip_time;
      volt <= 16'h1400;
      tick(4);
      outs(2'b00);
      rd(8'h1c, 32'h0, 2'h0);
      // Only the upper bytes are written, so the written 0xff in byte 1 pushes the value past the limit.
      s_axi_wstrb <= 4'he;
      wr(8'h08, 32'h0000ffff, 2'h0);
      s_axi_wstrb <= 4'hf;
      rd(8'h08, 32'hea60, 2'h0);
      volt <= 16'h2000;
      tick(4);
      outs(2'b10);
      // A reset in mid-run must drop the outputs and switch the function off again.
      aresetn <= 0;
      tick(3);
      outs(2'b00);
      aresetn <= 1;
      rd(8'h00, 32'h0, 2'h0);
      tick(4);
      outs(2'b00);
      tally_and_finish;
   end
endmodule
`default_nettype wire
